// File: rtl/cimc_pkg.sv
package cimc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE  = 8'h29;
    localparam logic [7:0] CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO  = 8'h2A;
    localparam logic [7:0] CIMC_OFS_TEMP_MASK     = 8'h2B;
    localparam logic [7:0] CIMC_OFS_FAULT_MASK_0  = 8'h2C;
    localparam logic [7:0] CIMC_OFS_FAULT_MASK_1  = 8'h2D;
    localparam logic [7:0] CIMC_OFS_MEAS_CTRL     = 8'h2E;
    localparam logic [7:0] CIMC_OFS_CHAN_OFF_0    = 8'h2F;
    // Flag registers, read-only, beside the masks
    localparam logic [7:0] CIMC_OFS_CHG_FLAG_ONE  = 8'h23;
    localparam logic [7:0] CIMC_OFS_CHG_FLAG_TWO  = 8'h24;
    localparam logic [7:0] CIMC_OFS_TEMP_FLAG     = 8'h25;
    localparam logic [7:0] CIMC_OFS_FAULT_FLAG_0  = 8'h26;
    localparam logic [7:0] CIMC_OFS_FAULT_FLAG_1  = 8'h27;

    // ************************************************************
    // Writable bit masks (implemented storage per register)
    // ************************************************************
    localparam logic [7:0] CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE   = 8'hD7;
    localparam logic [7:0] CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO   = 8'h7F;
    localparam logic [7:0] CIMC_WR_TEMP_MASK      = 8'h1F;
    localparam logic [7:0] CIMC_WR_FAULT_MASK_0   = 8'hFF;
    localparam logic [7:0] CIMC_WR_FAULT_MASK_1   = 8'hFC;
    localparam logic [7:0] CIMC_WR_MEAS_CTRL      = 8'hFF;
    localparam logic [7:0] CIMC_WR_CHAN_OFF_0     = 8'hFE;
    // Bits that watchdog expiry also clears
    localparam logic [7:0] CIMC_WDOG_TEMP_CLR     = 8'h0F;
    localparam logic [7:0] CIMC_WDOG_MEAS_CLR     = 8'h80;
    // Fault events with a flag of their own; spare bits 5..3 stay read-only zero
    localparam logic [7:0] CIMC_EVT_FAULT_MASK_1  = 8'hC4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] CIMC_RST_MASK          = 8'h00;
    localparam logic [7:0] CIMC_RST_MEAS_CTRL     = 8'h30;

    // ************************************************************
    // Measurement control field positions
    // ************************************************************
    localparam int CIMC_MEAS_EN_BIT    = 7;
    localparam int CIMC_MEAS_ONESHOT   = 6;
    localparam int CIMC_MEAS_SPEED_HI  = 5;
    localparam int CIMC_MEAS_SPEED_LO  = 4;
    localparam int CIMC_MEAS_AVG_BIT   = 3;
    localparam int CIMC_MEAS_SEED_BIT  = 2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] chg_one;
        logic [7:0] chg_two;
        logic [7:0] temp;
        logic [7:0] fault_0;
        logic [7:0] fault_1;
    } cimc_evt_t;

    typedef struct packed {
        logic       enable;
        logic       one_shot;
        logic [1:0] speed;
        logic       running_avg;
        logic       seed_fresh;
        logic [6:0] channel_off;
    } cimc_meas_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cimc_req_t;

endpackage : cimc_pkg

// File: rtl/cimc_regs.sv
`timescale 1ns/1ps
module cimc_regs
    import cimc_pkg::*;
(
    // Clock and reset
    input  wire logic      ref_clk_in,
    input  wire logic      nrst_in,
    // Register access from the serial front end (same clock)
    input  wire cimc_req_t req_in,
    output logic [7:0]     rdata_out,
    // Resets of the register file (same clock, one-cycle pulses)
    input  wire logic      reg_reset_in,
    input  wire logic      wdog_expire_in,
    // Event pulses from the charger core (same clock)
    input  wire cimc_evt_t evt_in,
    // Conversion pass finished (same clock)
    input  wire logic      conv_pass_done_in,
    // Measurement settings to the converter
    output cimc_meas_t     meas_out,
    // Interrupt pin, active low pulse
    output logic           irq_n_out
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] charge_state_change_irq_block_one;
    logic [7:0] charge_state_change_irq_block_two;
    logic [7:0] temp_mask;
    logic [7:0] fault_mask_0;
    logic [7:0] fault_mask_1;
    logic [7:0] meas_ctrl;
    logic [7:0] chan_off_0;
    cimc_evt_t  flag;
    cimc_evt_t  evt_full;
    cimc_evt_t  mask_all;
    cimc_evt_t  next_flag;
    logic       irq_pulse;

    // Write with a per-register mask of implemented bits
    function automatic logic [7:0] cimc_wr_merge(input logic [7:0] old_v,
                                                 input logic [7:0] new_v,
                                                 input logic [7:0] wmask);
        cimc_wr_merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction : cimc_wr_merge

    function automatic logic cimc_hit(input cimc_req_t r, input logic [7:0] ofs);
        cimc_hit = r.wr && (r.addr == ofs);
    endfunction : cimc_hit

    // ************************************************************
    // Charger mask registers
    // ************************************************************
    // Register reset clears everything; the watchdog does not touch these
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            charge_state_change_irq_block_one <= CIMC_RST_MASK;
            charge_state_change_irq_block_two <= CIMC_RST_MASK;
        end else if (reg_reset_in) begin
            charge_state_change_irq_block_one <= CIMC_RST_MASK;
            charge_state_change_irq_block_two <= CIMC_RST_MASK;
        end else begin
            if (cimc_hit(req_in, CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE)) begin
                charge_state_change_irq_block_one <= cimc_wr_merge(charge_state_change_irq_block_one, req_in.wdata,
                                              CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE);
            end
            if (cimc_hit(req_in, CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO)) begin
                charge_state_change_irq_block_two <= cimc_wr_merge(charge_state_change_irq_block_two, req_in.wdata,
                                              CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO);
            end
        end
    end

    // ************************************************************
    // Temperature zone mask
    // ************************************************************
    // Bit 4 is a spare read-write bit; only the zone bits clear on watchdog
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            temp_mask <= CIMC_RST_MASK;
        end else if (reg_reset_in) begin
            temp_mask <= CIMC_RST_MASK;
        end else if (wdog_expire_in) begin
            temp_mask <= temp_mask & ~CIMC_WDOG_TEMP_CLR;
        end else if (cimc_hit(req_in, CIMC_OFS_TEMP_MASK)) begin
            temp_mask <= cimc_wr_merge(temp_mask, req_in.wdata,
                                       CIMC_WR_TEMP_MASK);
        end
    end

    // ************************************************************
    // Fault mask registers
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fault_mask_0 <= CIMC_RST_MASK;
            fault_mask_1 <= CIMC_RST_MASK;
        end else if (reg_reset_in) begin
            fault_mask_0 <= CIMC_RST_MASK;
            fault_mask_1 <= CIMC_RST_MASK;
        end else begin
            if (cimc_hit(req_in, CIMC_OFS_FAULT_MASK_0)) begin
                fault_mask_0 <= cimc_wr_merge(fault_mask_0, req_in.wdata,
                                              CIMC_WR_FAULT_MASK_0);
            end
            if (cimc_hit(req_in, CIMC_OFS_FAULT_MASK_1)) begin
                fault_mask_1 <= cimc_wr_merge(fault_mask_1, req_in.wdata,
                                              CIMC_WR_FAULT_MASK_1);
            end
        end
    end

    // ************************************************************
    // Measurement control and channel disable
    // ************************************************************
    // Watchdog stops the converter but keeps the chosen mode and speed
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meas_ctrl  <= CIMC_RST_MEAS_CTRL;
            chan_off_0 <= CIMC_RST_MASK;
        end else if (reg_reset_in) begin
            meas_ctrl  <= CIMC_RST_MEAS_CTRL;
            chan_off_0 <= CIMC_RST_MASK;
        end else begin
            if (wdog_expire_in) begin
                meas_ctrl <= meas_ctrl & ~CIMC_WDOG_MEAS_CLR;
            end else if (cimc_hit(req_in, CIMC_OFS_MEAS_CTRL)) begin
                meas_ctrl <= cimc_wr_merge(meas_ctrl, req_in.wdata,
                                           CIMC_WR_MEAS_CTRL);
            end
            if (cimc_hit(req_in, CIMC_OFS_CHAN_OFF_0)) begin
                chan_off_0 <= cimc_wr_merge(chan_off_0, req_in.wdata,
                                            CIMC_WR_CHAN_OFF_0);
            end
        end
    end

    // Settings leave straight from the register flops
    always_comb begin
        meas_out.enable      = meas_ctrl[CIMC_MEAS_EN_BIT];
        meas_out.one_shot    = meas_ctrl[CIMC_MEAS_ONESHOT];
        meas_out.speed       = meas_ctrl[CIMC_MEAS_SPEED_HI:CIMC_MEAS_SPEED_LO];
        meas_out.running_avg = meas_ctrl[CIMC_MEAS_AVG_BIT];
        meas_out.seed_fresh  = meas_ctrl[CIMC_MEAS_SEED_BIT];
        meas_out.channel_off = chan_off_0[7:1];
    end

    // ************************************************************
    // Event flags and interrupt
    // ************************************************************
    // Conversion done only counts in single pass mode and with the converter on
    always_comb begin
        evt_full            = evt_in;
        evt_full.chg_two[5] = conv_pass_done_in && meas_ctrl[CIMC_MEAS_EN_BIT]
                              && meas_ctrl[CIMC_MEAS_ONESHOT];
        mask_all = {charge_state_change_irq_block_one & CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE,
                    charge_state_change_irq_block_two & CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO,
                    temp_mask & CIMC_WDOG_TEMP_CLR,
                    fault_mask_0,
                    fault_mask_1 & CIMC_WR_FAULT_MASK_1};
        evt_full = evt_full & {CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE, CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO,
                               CIMC_WDOG_TEMP_CLR, CIMC_WR_FAULT_MASK_0,
                               CIMC_EVT_FAULT_MASK_1};
    end

    // Flags clear on read of their register; a new event that cycle wins
    always_comb begin
        next_flag = flag;
        if (req_in.rd) begin
            case (req_in.addr)
                CIMC_OFS_CHG_FLAG_ONE: next_flag.chg_one = 8'h00;
                CIMC_OFS_CHG_FLAG_TWO: next_flag.chg_two = 8'h00;
                CIMC_OFS_TEMP_FLAG:    next_flag.temp    = 8'h00;
                CIMC_OFS_FAULT_FLAG_0: next_flag.fault_0 = 8'h00;
                CIMC_OFS_FAULT_FLAG_1: next_flag.fault_1 = 8'h00;
                default:               next_flag         = flag;
            endcase
        end
        next_flag = next_flag | evt_full;
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

    // One low cycle for any unmasked event whose flag is not already set; masks never gate the flags
    assign irq_pulse = |(evt_full & ~flag & ~mask_all);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_n_out <= 1'b1;
        end else begin
            irq_n_out <= ~irq_pulse;
        end
    end

    // ************************************************************
    // Read back
    // ************************************************************
    // Unmapped addresses read zero
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else if (req_in.rd) begin
            case (req_in.addr)
                CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE: rdata_out <= charge_state_change_irq_block_one;
                CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO: rdata_out <= charge_state_change_irq_block_two;
                CIMC_OFS_TEMP_MASK:    rdata_out <= temp_mask;
                CIMC_OFS_FAULT_MASK_0: rdata_out <= fault_mask_0;
                CIMC_OFS_FAULT_MASK_1: rdata_out <= fault_mask_1;
                CIMC_OFS_MEAS_CTRL:    rdata_out <= meas_ctrl;
                CIMC_OFS_CHAN_OFF_0:   rdata_out <= chan_off_0;
                CIMC_OFS_CHG_FLAG_ONE: rdata_out <= flag.chg_one;
                CIMC_OFS_CHG_FLAG_TWO: rdata_out <= flag.chg_two;
                CIMC_OFS_TEMP_FLAG:    rdata_out <= flag.temp;
                CIMC_OFS_FAULT_FLAG_0: rdata_out <= flag.fault_0;
                CIMC_OFS_FAULT_FLAG_1: rdata_out <= flag.fault_1;
                default:               rdata_out <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence unmasked_evt_s;
        (evt_full.chg_one[7] && !flag.chg_one[7] && !charge_state_change_irq_block_one[7]);
    endsequence

    charge_irq_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        unmasked_evt_s |=> !irq_n_out)
        else $error("unmasked charge event did not pulse interrupt");

    masked_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ((evt_full & ~flag & ~mask_all) == '0) |=> irq_n_out)
        else $error("interrupt pulsed without unmasked new event");

    flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        evt_in.fault_0[6] |=> flag.fault_0[6])
        else $error("event did not set its flag");

    conv_done_mode_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (conv_pass_done_in && !meas_ctrl[CIMC_MEAS_ONESHOT] && !flag.chg_two[5]
         && !(req_in.rd && req_in.addr == CIMC_OFS_CHG_FLAG_TWO))
        |=> !flag.chg_two[5])
        else $error("conversion done flag set in continuous mode");

    wdog_clear_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (wdog_expire_in && !reg_reset_in && !req_in.wr) |=>
        (temp_mask[3:0] == 4'h0) && !meas_ctrl[7]
        && (meas_ctrl[6:0] == $past(meas_ctrl[6:0]))
        && charge_state_change_irq_block_one == $past(charge_state_change_irq_block_one))
        else $error("watchdog clear wrong");

    reg_reset_val_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        reg_reset_in |=> (meas_ctrl == 8'h30) && (fault_mask_0 == 8'h00))
        else $error("register reset value wrong");

    reserved_zero_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (charge_state_change_irq_block_one[5] == 1'b0) && (charge_state_change_irq_block_two[7] == 1'b0)
        && (temp_mask[7:5] == 3'h0) && (fault_mask_1[1:0] == 2'h0)
        && (chan_off_0[0] == 1'b0))
        else $error("reserved read-only bit not zero");

    meas_write_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cimc_hit(req_in, CIMC_OFS_MEAS_CTRL) && !reg_reset_in && !wdog_expire_in)
        |=> (meas_out.enable == $past(req_in.wdata[7]))
        && (meas_out.speed == $past(req_in.wdata[5:4])))
        else $error("measurement enable or speed did not follow write");

    meas_mode_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cimc_hit(req_in, CIMC_OFS_MEAS_CTRL) && !reg_reset_in && !wdog_expire_in)
        |=> (meas_out.one_shot == $past(req_in.wdata[6]))
        && (meas_out.running_avg == $past(req_in.wdata[3]))
        && (meas_out.seed_fresh == $past(req_in.wdata[2])))
        else $error("measurement mode bits did not follow write");

    chan_off_write_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cimc_hit(req_in, CIMC_OFS_CHAN_OFF_0) && !reg_reset_in)
        |=> meas_out.channel_off == $past(req_in.wdata[7:1]))
        else $error("channel disable bits did not follow write");

    chg_one_write_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cimc_hit(req_in, CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE) && !reg_reset_in)
        |=> charge_state_change_irq_block_one == ($past(req_in.wdata) & CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_ONE))
        else $error("charger mask one write wrong");

    chg_two_write_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cimc_hit(req_in, CIMC_OFS_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO) && !reg_reset_in)
        |=> charge_state_change_irq_block_two == ($past(req_in.wdata) & CIMC_WR_CHARGE_STATE_CHANGE_IRQ_BLOCK_TWO))
        else $error("charger mask two write wrong");

    temp_write_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cimc_hit(req_in, CIMC_OFS_TEMP_MASK) && !reg_reset_in && !wdog_expire_in)
        |=> temp_mask == ($past(req_in.wdata) & CIMC_WR_TEMP_MASK))
        else $error("temperature mask write wrong");

    fault_one_write_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cimc_hit(req_in, CIMC_OFS_FAULT_MASK_1) && !reg_reset_in)
        |=> fault_mask_1 == ($past(req_in.wdata) & CIMC_WR_FAULT_MASK_1))
        else $error("fault mask one write wrong");

    // A raised flag may only fall through a read of its own register
    flag_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (flag.temp[0] && !(req_in.rd && req_in.addr == CIMC_OFS_TEMP_FLAG))
        |=> flag.temp[0])
        else $error("flag fell without a read");

    reserved_flag_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (flag.chg_one[5] == 1'b0) && (flag.chg_one[3] == 1'b0)
        && (flag.chg_two[7] == 1'b0) && (flag.temp[7:4] == 4'h0)
        && (flag.fault_1[5:3] == 3'h0) && (flag.fault_1[1:0] == 2'h0))
        else $error("reserved flag bit not zero");

    conv_single_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (conv_pass_done_in && meas_out.enable && meas_out.one_shot
         && !charge_state_change_irq_block_two[5] && !flag.chg_two[5])
        |=> !irq_n_out)
        else $error("single pass done did not pulse interrupt");

endmodule : cimc_regs

// File: tb/cimc_core_model.sv
`timescale 1ns/1ps
// ************************************************************
// Charger core and interrupt listener model
// ************************************************************
module cimc_core_model
    import cimc_pkg::*;
(
    // Clock
    input  wire logic ref_clk_in,
    // Interrupt line from the register bank
    input  wire logic irq_n_in,
    // Event pulses toward the register bank
    output cimc_evt_t evt_out,
    output logic      done_out
);
    int irq_cnt = 0;

    // Events idle low from time zero
    initial begin
        evt_out  = '0;
        done_out = 1'b0;
    end

    // Count low cycles; a pulse wider than one cycle shows up as extra counts
    always @(posedge ref_clk_in) begin
        if (irq_n_in === 1'b0) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    // One-cycle event pulse, then room for the registered interrupt to land
    task automatic fire(input cimc_evt_t e, input logic d);
        @(posedge ref_clk_in);
        evt_out  <= e;
        done_out <= d;
        @(posedge ref_clk_in);
        evt_out  <= '0;
        done_out <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
    endtask : fire
endmodule : cimc_core_model

// File: tb/cimc_regs_tb.sv
`timescale 1ns/1ps
// ************************************************************
// Register bank testbench
// ************************************************************
module cimc_regs_tb
    import cimc_pkg::*;
;
    logic       ref_clk_in;
    logic       nrst_in;
    cimc_req_t  req_in;
    logic [7:0] rdata_out;
    logic       reg_reset_in;
    logic       wdog_expire_in;
    cimc_evt_t  evt_in;
    logic       conv_pass_done_in;
    cimc_meas_t meas_out;
    logic       irq_n_out;
    int         error_cnt = 0;
    int         samples_checked = 0;
    localparam logic [7:0] OFS [7] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
    localparam logic [7:0] WRM [7] = '{8'hD7, 8'h7F, 8'h1F, 8'hFF, 8'hFC, 8'hFF, 8'hFE};
    // Event bits per mask register; conversion done is driven on its own input
    localparam logic [7:0] EVM [5] = '{8'hD7, 8'h5F, 8'h0F, 8'hFF, 8'hC4};

    cimc_regs cimc_regs_i (
        .ref_clk_in        (ref_clk_in),
        .nrst_in           (nrst_in),
        .req_in            (req_in),
        .rdata_out         (rdata_out),
        .reg_reset_in      (reg_reset_in),
        .wdog_expire_in    (wdog_expire_in),
        .evt_in            (evt_in),
        .conv_pass_done_in (conv_pass_done_in),
        .meas_out          (meas_out),
        .irq_n_out         (irq_n_out)
    );

    cimc_core_model cimc_core_model_i (
        .ref_clk_in (ref_clk_in),
        .irq_n_in   (irq_n_out),
        .evt_out    (evt_in),
        .done_out   (conv_pass_done_in)
    );

    // 10 MHz clock
    initial ref_clk_in = 1'b0;
    always #50 ref_clk_in = ~ref_clk_in;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk

    // Strobe held for one edge, released at the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_in);
        req_in <= '0;
    endtask : wr

    // Read data is registered and holds, so it is taken after the release edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk_in);
        req_in <= '0;
        #1 d = rdata_out;
    endtask : rd

    // Watchdog: the whole run needs under 2000 cycles
    initial begin
        #2000000;
        $display("FAIL watchdog expected done seen hang");
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        logic [7:0] d;
        cimc_evt_t  e;
        int         n;
        nrst_in        = 1'b0;
        req_in         = '0;
        reg_reset_in   = 1'b0;
        wdog_expire_in = 1'b0;
        repeat (8) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        chk("meas_out reset", 16'h0600, 16'(meas_out));
        chk("irq_n idle", 16'h0001, 16'(irq_n_out));
        for (int i = 0; i < 7; i++) begin
            rd(OFS[i], d);
            chk("reset value", (i == 5) ? 16'h0030 : 16'h0000, 16'(d));
        end
        rd(8'h50, d);
        chk("unmapped read", 16'h0000, 16'(d));
        $display("test reset values done");
        // All ones: reserved read-only bits must stay zero
        for (int i = 0; i < 7; i++) begin
            wr(OFS[i], 8'hFF);
            rd(OFS[i], d);
            chk("write ones", 16'(WRM[i]), 16'(d));
        end
        chk("meas_out ones", 16'h1FFF, 16'(meas_out));
        wr(8'h2E, 8'hA5);
        #1 chk("meas_out pattern", 16'h14FF, 16'(meas_out));
        $display("test access kinds done");
        // Watchdog clears only the thermal masks and the enable bit
        @(posedge ref_clk_in);
        wdog_expire_in <= 1'b1;
        @(posedge ref_clk_in);
        wdog_expire_in <= 1'b0;
        rd(8'h2B, d);
        chk("temp mask after wdog", 16'h0010, 16'(d));
        rd(8'h2E, d);
        chk("meas ctrl after wdog", 16'h0025, 16'(d));
        rd(8'h29, d);
        chk("mask one after wdog", 16'h00D7, 16'(d));
        @(posedge ref_clk_in);
        reg_reset_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_reset_in <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(OFS[i], d);
            chk("after reg reset", (i == 5) ? 16'h0030 : 16'h0000, 16'(d));
        end
        $display("test reset sources done");
        // Each event unmasked then masked; the flag sets either way
        for (int i = 0; i < 5; i++) begin
            for (int b = 0; b < 8; b++) begin
                if (EVM[i][b]) begin
                    e = '0;
                    e[8 * (4 - i) + b] = 1'b1;
                    n = cimc_core_model_i.irq_cnt;
                    cimc_core_model_i.fire(e, 1'b0);
                    chk("irq unmasked", 16'(n + 1), 16'(cimc_core_model_i.irq_cnt));
                    rd(8'h23 + 8'(i), d);
                    chk("flag unmasked", 16'(8'h01 << b), 16'(d));
                    wr(8'h29 + 8'(i), 8'h01 << b);
                    cimc_core_model_i.fire(e, 1'b0);
                    chk("irq masked", 16'(n + 1), 16'(cimc_core_model_i.irq_cnt));
                    rd(8'h23 + 8'(i), d);
                    chk("flag masked", 16'(8'h01 << b), 16'(d));
                    wr(8'h29 + 8'(i), 8'h00);
                end
            end
        end
        $display("test event masks done");
        // Spare event bits raise nothing; a repeat on a raised flag stays quiet
        e = '0;
        e.chg_one = 8'h28;
        e.fault_1 = 8'h38;
        n = cimc_core_model_i.irq_cnt;
        cimc_core_model_i.fire(e, 1'b0);
        chk("reserved irq", 16'(n), 16'(cimc_core_model_i.irq_cnt));
        rd(8'h27, d);
        chk("reserved fault flag", 16'h0000, 16'(d));
        rd(8'h23, d);
        chk("reserved charger flag", 16'h0000, 16'(d));
        e = '0;
        e.fault_0 = 8'h01;
        cimc_core_model_i.fire(e, 1'b0);
        cimc_core_model_i.fire(e, 1'b0);
        chk("repeat irq", 16'(n + 1), 16'(cimc_core_model_i.irq_cnt));
        rd(8'h26, d);
        chk("repeat flag", 16'h0001, 16'(d));
        $display("test reserved and repeat events done");
        // Conversion done counts only in single-pass mode
        wr(8'h2E, 8'h80);
        n = cimc_core_model_i.irq_cnt;
        cimc_core_model_i.fire('0, 1'b1);
        chk("done continuous irq", 16'(n), 16'(cimc_core_model_i.irq_cnt));
        rd(8'h24, d);
        chk("done continuous flag", 16'h0000, 16'(d));
        wr(8'h2E, 8'hC0);
        cimc_core_model_i.fire('0, 1'b1);
        chk("done single irq", 16'(n + 1), 16'(cimc_core_model_i.irq_cnt));
        rd(8'h24, d);
        chk("done single flag", 16'h0020, 16'(d));
        wr(8'h2A, 8'h20);
        cimc_core_model_i.fire('0, 1'b1);
        chk("done masked irq", 16'(n + 1), 16'(cimc_core_model_i.irq_cnt));
        rd(8'h24, d);
        chk("done masked flag", 16'h0020, 16'(d));
        $display("test conversion done");
        print_verdict();
    end
endmodule : cimc_regs_tb
